// ==== core/stu_defs.svh ====
// Constants of the stack transfer unit: opcodes, field positions, timings
`ifndef STU_DEFS_SVH
`define STU_DEFS_SVH

// Prefix and opcode bytes
`define STU_OP_PFX_FIRST 8'hdd
`define STU_OP_PFX_SECOND 8'hfd
`define STU_OP_STORE_ABS 8'h22
`define STU_OP_LOAD_SP 8'hf9
`define STU_OP_PUSH_IDX 8'he5
`define STU_OP_POP_IDX 8'he1

// Stack pair opcode pattern 11qqxxxx
`define STU_PSEL_HI 5
`define STU_PSEL_LO 4
`define STU_GRP_HI 7
`define STU_GRP_LO 6
`define STU_GRP_STACK 2'h3
`define STU_TAIL_PUSH 4'h5
`define STU_TAIL_POP 4'h1

// Clock states per machine cycle, one clock per state
`define STU_T_FETCH 3'h4
`define STU_T_MEM 3'h3
`define STU_T_EXT_SP 3'h2
`define STU_T_EXT_PUSH 3'h1

// Reset values
`define STU_RST_WORD 16'h0000
`define STU_RST_BYTE 8'h00

`endif

// ==== core/stu_pkg.sv ====
// Types shared by the stack transfer unit and its bench
package stu_pkg;

    // Sequencer states, one per kind of machine cycle
    typedef enum logic [3:0] {
        STU_ST_IDLE = 4'h0,
        STU_ST_FETCH = 4'h1,
        STU_ST_EXT = 4'h2,
        STU_ST_ADR_LO = 4'h3,
        STU_ST_ADR_HI = 4'h4,
        STU_ST_STO_LO = 4'h5,
        STU_ST_STO_HI = 4'h6,
        STU_ST_PUSH_HI = 4'h7,
        STU_ST_PUSH_LO = 4'h8,
        STU_ST_POP_LO = 4'h9,
        STU_ST_POP_HI = 4'ha
    } stu_state_e;

    // Active prefix of the instruction in flight
    typedef enum logic [1:0] {
        STU_PFX_NONE = 2'h0,
        STU_PFX_FIRST = 2'h1,
        STU_PFX_SECOND = 2'h2
    } stu_pfx_e;

    // Preload target selector
    typedef enum logic [2:0] {
        STU_SEL_PAIR_ZERO = 3'h0,
        STU_SEL_PAIR_ONE = 3'h1,
        STU_SEL_PAIR_TWO = 3'h2,
        STU_SEL_ACCUM_FLAGS = 3'h3,
        STU_SEL_FIRST_INDEX = 3'h4,
        STU_SEL_SECOND_INDEX = 3'h5,
        STU_SEL_STACK_POINTER = 3'h6,
        STU_SEL_PROG_COUNTER = 3'h7
    } stu_sel_e;

    // Memory cycle request towards external memory
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } stu_mem_s;

    // Architectural register view
    typedef struct packed {
        logic [15:0] pair_zero;
        logic [15:0] pair_one;
        logic [15:0] pair_two;
        logic [15:0] accum_flags_pair;
        logic [15:0] first_index_register;
        logic [15:0] second_index_register;
        logic [15:0] stack_pointer;
        logic [15:0] prog_counter;
    } stu_regs_s;

endpackage : stu_pkg

// ==== core/stu_core.sv ====
// Stack transfer unit: sequencer for index store, stack pointer loads, push and pop
`timescale 1ns/1ps
`include "stu_defs.svh"

// How it works
// - FD 22 nn stores second index, low first
// - F9 copies pair_two into stack pointer
// - DD F9 copies first index, 4,6 states
// - FD F9 copies second index, 4,6 states
// - Pair push: high at sp-1, low at sp-2
// - Bits 5:4 pick zero, one, two, accum
// - DD E5 pushes first index, 4,5,3,3
// - FD E5 pushes second index, same timing
// - Sixteen-bit pointer, push down, pop up
// - Pair pop: low at sp, high at sp+1
// - DD E1 pops first index, 4,4,3,3
// - Second index pop, 4,4,3,3 states
module stu_core
    import stu_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Instruction start and status
    input wire logic start_i,
    output logic busy_o,
    output logic done_o,
    output logic illegal_o,
    output logic mcycle_start_o,
    // Register preload while idle
    input wire logic load_en_i,
    input wire stu_sel_e load_sel_i,
    input wire logic [15:0] load_val_i,
    // External memory
    output stu_mem_s mem_o,
    input wire logic [7:0] mem_rdata_i,
    // Register view
    output stu_regs_s regs_o
);

    // Reset release synchroniser
    logic [1:0] rst_sync_q;
    wire rst_n = rst_sync_q[1];
    // Sequencer
    stu_state_e state_q, state_d;
    logic [2:0] tcnt_q, tcnt_d;        // States left in this machine cycle
    stu_pfx_e pfx_q, pfx_d;
    logic [7:0] op_q, op_d;            // Opcode after the prefix
    logic [15:0] nn_q, nn_d;           // Absolute operand address
    logic [7:0] lo_q, lo_d;            // Low byte held during a pop
    // Architectural registers
    logic [15:0] pair_q [4];           // Indexed by stack_pair_select
    logic [15:0] pair_d [4];
    logic [15:0] first_index_q, first_index_d;
    logic [15:0] second_index_q, second_index_d;
    logic [15:0] sp_q, sp_d;
    logic [15:0] pc_q, pc_d;
    // Registered outputs
    stu_mem_s mem_q, mem_d;
    logic done_q, done_d;
    logic illegal_q, illegal_d;
    logic mstart_q, mstart_d;
    // Decode of the byte arriving at the end of a fetch
    wire [7:0] byte_in = mem_rdata_i;
    wire end_of_cycle = (tcnt_q == 3'h0);
    wire is_pfx_first = (byte_in == `STU_OP_PFX_FIRST);
    wire is_pfx_second = (byte_in == `STU_OP_PFX_SECOND);
    wire no_pfx = (pfx_q == STU_PFX_NONE);
    wire grp_stack = (byte_in[`STU_GRP_HI:`STU_GRP_LO] == `STU_GRP_STACK);
    wire dec_load_sp = (byte_in == `STU_OP_LOAD_SP);
    wire dec_store = (pfx_q == STU_PFX_SECOND) && (byte_in == `STU_OP_STORE_ABS);
    wire dec_push = no_pfx ? (grp_stack && byte_in[3:0] == `STU_TAIL_PUSH)
                           : (byte_in == `STU_OP_PUSH_IDX);
    wire dec_pop = no_pfx ? (grp_stack && byte_in[3:0] == `STU_TAIL_POP)
                          : (byte_in == `STU_OP_POP_IDX);
    // Source and target selection for the latched opcode
    wire [1:0] pair_sel = op_q[`STU_PSEL_HI:`STU_PSEL_LO];
    wire [15:0] index_val = (pfx_q == STU_PFX_FIRST) ? first_index_q : second_index_q;
    wire [15:0] src_val = no_pfx ? pair_q[pair_sel] : index_val;
    wire [15:0] sp_dec = sp_q - 16'h0001;
    wire [15:0] sp_inc = sp_q + 16'h0001;
    wire [15:0] pc_inc = pc_q + 16'h0001;
    wire [15:0] nn_inc = nn_q + 16'h0001;

    // Handshake status
    assign busy_o = (state_q != STU_ST_IDLE);

    // Next-state and datapath
    always_comb begin
        state_d = state_q;
        tcnt_d = end_of_cycle ? tcnt_q : tcnt_q - 3'h1;
        pfx_d = pfx_q;
        op_d = op_q;
        nn_d = nn_q;
        lo_d = lo_q;
        pair_d = pair_q;
        first_index_d = first_index_q;
        second_index_d = second_index_q;
        sp_d = sp_q;
        pc_d = pc_q;
        mem_d = mem_q;
        done_d = 1'b0;
        illegal_d = 1'b0;
        mstart_d = 1'b0;
        // Flags in accum_flags_pair change only by preload or a pop into that pair
        case (state_q)
            STU_ST_IDLE: begin
                // Preload path, refused while busy
                if (load_en_i) begin
                    case (load_sel_i)
                        STU_SEL_FIRST_INDEX: first_index_d = load_val_i;
                        STU_SEL_SECOND_INDEX: second_index_d = load_val_i;
                        STU_SEL_STACK_POINTER: sp_d = load_val_i;
                        STU_SEL_PROG_COUNTER: pc_d = load_val_i;
                        default: pair_d[load_sel_i[1:0]] = load_val_i;
                    endcase
                end
                // A program counter preload at start still lands; the fetch uses the old value
                if (start_i) begin
                    state_d = STU_ST_FETCH;
                    tcnt_d = `STU_T_FETCH - 3'h1;
                    pfx_d = STU_PFX_NONE;
                    mem_d = '{addr: pc_q, wdata: `STU_RST_BYTE, rd: 1'b1, wr: 1'b0};
                    mstart_d = 1'b1;
                end
            end
            STU_ST_FETCH: begin
                if (end_of_cycle) begin
                    pc_d = pc_inc;
                    mem_d.rd = 1'b0;
                    mstart_d = 1'b1;
                    if (no_pfx && (is_pfx_first || is_pfx_second)) begin
                        // Prefix byte: fetch the opcode proper
                        pfx_d = is_pfx_first ? STU_PFX_FIRST : STU_PFX_SECOND;
                        tcnt_d = `STU_T_FETCH - 3'h1;
                        mem_d = '{addr: pc_inc, wdata: `STU_RST_BYTE, rd: 1'b1, wr: 1'b0};
                    end else begin
                        op_d = byte_in;
                        if (dec_load_sp) begin
                            // Stretch this cycle to six states
                            state_d = STU_ST_EXT;
                            tcnt_d = `STU_T_EXT_SP - 3'h1;
                            mstart_d = 1'b0;
                        end else if (dec_push) begin
                            // One extra state to step the pointer
                            state_d = STU_ST_EXT;
                            tcnt_d = `STU_T_EXT_PUSH - 3'h1;
                            mstart_d = 1'b0;
                        end else if (dec_store) begin
                            state_d = STU_ST_ADR_LO;
                            tcnt_d = `STU_T_MEM - 3'h1;
                            mem_d = '{addr: pc_inc, wdata: `STU_RST_BYTE, rd: 1'b1, wr: 1'b0};
                        end else if (dec_pop) begin
                            state_d = STU_ST_POP_LO;
                            tcnt_d = `STU_T_MEM - 3'h1;
                            mem_d = '{addr: sp_q, wdata: `STU_RST_BYTE, rd: 1'b1, wr: 1'b0};
                        end else begin
                            // Not an instruction of this group
                            state_d = STU_ST_IDLE;
                            illegal_d = 1'b1;
                            done_d = 1'b1;
                            mstart_d = 1'b0;
                        end
                    end
                end
            end
            STU_ST_EXT: begin
                if (end_of_cycle) begin
                    mstart_d = 1'b1;
                    if (op_q == `STU_OP_LOAD_SP) begin
                        // Whole word copy, no memory cycle
                        sp_d = no_pfx ? pair_q[2] : index_val;
                        state_d = STU_ST_IDLE;
                        done_d = 1'b1;
                        mstart_d = 1'b0;
                    end else begin
                        // High byte goes to the first decremented address
                        sp_d = sp_dec;
                        state_d = STU_ST_PUSH_HI;
                        tcnt_d = `STU_T_MEM - 3'h1;
                        mem_d = '{addr: sp_dec, wdata: src_val[15:8], rd: 1'b0, wr: 1'b1};
                    end
                end
            end
            STU_ST_PUSH_HI: begin
                if (end_of_cycle) begin
                    // Low byte goes one lower
                    sp_d = sp_dec;
                    state_d = STU_ST_PUSH_LO;
                    tcnt_d = `STU_T_MEM - 3'h1;
                    mem_d = '{addr: sp_dec, wdata: src_val[7:0], rd: 1'b0, wr: 1'b1};
                    mstart_d = 1'b1;
                end
            end
            STU_ST_POP_LO: begin
                if (end_of_cycle) begin
                    // Low byte read, pointer steps up
                    lo_d = byte_in;
                    sp_d = sp_inc;
                    state_d = STU_ST_POP_HI;
                    tcnt_d = `STU_T_MEM - 3'h1;
                    mem_d = '{addr: sp_inc, wdata: `STU_RST_BYTE, rd: 1'b1, wr: 1'b0};
                    mstart_d = 1'b1;
                end
            end
            STU_ST_POP_HI: begin
                if (end_of_cycle) begin
                    // High byte read, pointer steps up again
                    sp_d = sp_inc;
                    if (no_pfx) begin
                        pair_d[pair_sel] = {byte_in, lo_q};
                    end else if (pfx_q == STU_PFX_FIRST) begin
                        first_index_d = {byte_in, lo_q};
                    end else begin
                        second_index_d = {byte_in, lo_q};
                    end
                    state_d = STU_ST_IDLE;
                    mem_d.rd = 1'b0;
                    done_d = 1'b1;
                end
            end
            STU_ST_ADR_LO: begin
                if (end_of_cycle) begin
                    // Operand address arrives low byte first
                    nn_d[7:0] = byte_in;
                    pc_d = pc_inc;
                    state_d = STU_ST_ADR_HI;
                    tcnt_d = `STU_T_MEM - 3'h1;
                    mem_d = '{addr: pc_inc, wdata: `STU_RST_BYTE, rd: 1'b1, wr: 1'b0};
                    mstart_d = 1'b1;
                end
            end
            STU_ST_ADR_HI: begin
                if (end_of_cycle) begin
                    nn_d[15:8] = byte_in;
                    pc_d = pc_inc;
                    state_d = STU_ST_STO_LO;
                    tcnt_d = `STU_T_MEM - 3'h1;
                    mem_d = '{addr: {byte_in, nn_q[7:0]}, wdata: second_index_q[7:0],
                              rd: 1'b0, wr: 1'b1};
                    mstart_d = 1'b1;
                end
            end
            STU_ST_STO_LO: begin
                if (end_of_cycle) begin
                    // High byte to the next address up
                    state_d = STU_ST_STO_HI;
                    tcnt_d = `STU_T_MEM - 3'h1;
                    mem_d = '{addr: nn_inc, wdata: second_index_q[15:8],
                              rd: 1'b0, wr: 1'b1};
                    mstart_d = 1'b1;
                end
            end
            STU_ST_PUSH_LO, STU_ST_STO_HI: begin
                // Last write cycle of a push or a store
                if (end_of_cycle) begin
                    state_d = STU_ST_IDLE;
                    mem_d.wr = 1'b0;
                    done_d = 1'b1;
                end
            end
            default: begin
                state_d = STU_ST_IDLE;
                mem_d.rd = 1'b0;
                mem_d.wr = 1'b0;
            end
        endcase
    end

    // Reset release through two flops
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    // Register pairs, one per stack_pair_select code
    for (genvar i = 0; i < 4; i++) begin : g_pair
        always_ff @(posedge sys_clk_i or negedge rst_n) begin
            if (!rst_n) begin
                pair_q[i] <= `STU_RST_WORD;
            end else begin
                pair_q[i] <= pair_d[i];
            end
        end
    end

    // Sequencer and remaining registers
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= STU_ST_IDLE;
            tcnt_q <= 3'h0;
            pfx_q <= STU_PFX_NONE;
            op_q <= `STU_RST_BYTE;
            nn_q <= `STU_RST_WORD;
            lo_q <= `STU_RST_BYTE;
            first_index_q <= `STU_RST_WORD;
            second_index_q <= `STU_RST_WORD;
            sp_q <= `STU_RST_WORD;
            pc_q <= `STU_RST_WORD;
            mem_q <= '0;
            done_q <= 1'b0;
            illegal_q <= 1'b0;
            mstart_q <= 1'b0;
        end else begin
            state_q <= state_d;
            tcnt_q <= tcnt_d;
            pfx_q <= pfx_d;
            op_q <= op_d;
            nn_q <= nn_d;
            lo_q <= lo_d;
            first_index_q <= first_index_d;
            second_index_q <= second_index_d;
            sp_q <= sp_d;
            pc_q <= pc_d;
            mem_q <= mem_d;
            done_q <= done_d;
            illegal_q <= illegal_d;
            mstart_q <= mstart_d;
        end
    end

    // Output wiring
    assign mem_o = mem_q;
    assign done_o = done_q;
    assign illegal_o = illegal_q;
    assign mcycle_start_o = mstart_q;
    assign regs_o = '{pair_zero: pair_q[0], pair_one: pair_q[1], pair_two: pair_q[2],
                      accum_flags_pair: pair_q[3], first_index_register: first_index_q,
                      second_index_register: second_index_q, stack_pointer: sp_q,
                      prog_counter: pc_q};

endmodule : stu_core

// ==== sim/stu_core_asserts.sv ====
// Concurrent checks on the stack transfer unit ports
`timescale 1ns/1ps
module stu_core_asserts
    import stu_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Control and status
    input wire logic start_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic illegal_o,
    input wire logic mcycle_start_o,
    // Preload
    input wire logic load_en_i,
    input wire stu_sel_e load_sel_i,
    input wire logic [15:0] load_val_i,
    // Memory and register view
    input wire stu_mem_s mem_o,
    input wire logic [7:0] mem_rdata_i,
    input wire stu_regs_s regs_o
);
    // One domain, one reset
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    // Flags change only by a finished pop or a preload
    a_flags_hold: assert property ($changed(regs_o.accum_flags_pair) |-> done_o ||
        $past(load_en_i && !busy_o && load_sel_i == STU_SEL_ACCUM_FLAGS))
        else $error("flags changed outside pop or preload");
    // Stack pointer moves at completion, by one at a cycle start, or by preload
    a_sp_update: assert property ($changed(regs_o.stack_pointer) |-> done_o ||
        (mcycle_start_o && (regs_o.stack_pointer == $past(regs_o.stack_pointer) + 16'h0001 ||
        regs_o.stack_pointer == $past(regs_o.stack_pointer) - 16'h0001)) ||
        $past(load_en_i && !busy_o && load_sel_i == STU_SEL_STACK_POINTER))
        else $error("stack pointer moved outside a step or preload");
    // Accepted start begins a fetch at the program counter
    a_fetch_begin: assert property (!busy_o && start_i |=> mcycle_start_o &&
        mem_o.rd && mem_o.addr == $past(regs_o.prog_counter))
        else $error("fetch did not begin after start");
    // Fetch reads for four clocks
    a_fetch_len: assert property ($rose(busy_o) |-> mem_o.rd [*4])
        else $error("fetch cycle not four clocks");
    // Write cycle lasts three clocks
    a_write_len: assert property (mcycle_start_o && mem_o.wr |->
        mem_o.wr [*3] ##1 (!mem_o.wr || mcycle_start_o))
        else $error("write cycle not three clocks");
    // Address and data hold through a write
    a_write_hold: assert property (mem_o.wr && !mcycle_start_o |->
        $stable(mem_o.addr) && $stable(mem_o.wdata))
        else $error("write address or data moved");
    // Never read and write together
    a_rw_apart: assert property (!(mem_o.rd && mem_o.wr))
        else $error("read and write at once");
    // Completion pulses once, with the read strobe released
    a_done_end: assert property ($fell(busy_o) |-> done_o && !mem_o.rd ##1 !done_o)
        else $error("completion pulse wrong");
    // Illegal flag only with completion
    a_illegal_done: assert property (illegal_o |-> done_o)
        else $error("illegal without done");

    // Main scenarios reached
    c_write: cover property (mcycle_start_o && mem_o.wr);
    c_done: cover property (done_o && !illegal_o);
    c_illegal: cover property (illegal_o);
endmodule : stu_core_asserts

bind stu_core stu_core_asserts i_asserts (.sys_clk_i, .reset_n_i, .start_i, .busy_o,
    .done_o, .illegal_o, .mcycle_start_o, .load_en_i, .load_sel_i, .load_val_i, .mem_o,
    .mem_rdata_i, .regs_o);

// ==== sim/stu_mem_model.sv ====
// External memory holding program, operands and stack
`timescale 1ns/1ps
module stu_mem_model
    import stu_pkg::*;
(
    // Clock
    input wire logic sys_clk_i,
    // Memory cycle from the unit
    input wire stu_mem_s mem_i,
    output logic [7:0] rdata_o
);
    // Full 16-bit address space
    logic [7:0] mem [0:65535];
    // Last byte driven, inverted when released
    logic [7:0] last_q = 8'h00;

    // Released data lines show the inverse of the last byte
    assign rdata_o = mem_i.rd ? mem[mem_i.addr] : ~last_q;

    // Store writes, remember reads
    always @(posedge sys_clk_i) begin
        if (mem_i.wr) begin
            mem[mem_i.addr] <= mem_i.wdata;
        end
        if (mem_i.rd) begin
            last_q <= mem[mem_i.addr];
        end
    end
endmodule : stu_mem_model

// ==== sim/tb.sv ====
// Self-checking bench of the stack transfer unit
`timescale 1ns/1ps
module tb;
    import stu_pkg::*;
    // Design inputs
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic start_i = 1'b0;
    logic load_en_i = 1'b0;
    stu_sel_e load_sel_i = STU_SEL_PAIR_ZERO;
    logic [15:0] load_val_i = 16'h0000;
    // Design outputs
    logic busy_o, done_o, illegal_o, mcycle_start_o;
    stu_mem_s mem_o;
    logic [7:0] mem_rdata_i;
    stu_regs_s regs_o;
    // Result counters
    int fail_count = 0;
    int n_compared = 0;

    // 100 ns clock
    always #50 sys_clk_i = ~sys_clk_i;

    stu_core i_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .start_i(start_i),
        .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o),
        .mcycle_start_o(mcycle_start_o), .load_en_i(load_en_i), .load_sel_i(load_sel_i),
        .load_val_i(load_val_i), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i), .regs_o(regs_o));
    stu_mem_model i_mem (.sys_clk_i(sys_clk_i), .mem_i(mem_o), .rdata_o(mem_rdata_i));

    // Compare and count
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask : chk

    // Preload one register while idle
    task automatic preload(input stu_sel_e sel, input logic [15:0] val);
        @(posedge sys_clk_i) begin
            load_en_i <= 1'b1;
            load_sel_i <= sel;
            load_val_i <= val;
        end
        @(posedge sys_clk_i) load_en_i <= 1'b0;
    endtask : preload

    // Place bytes at 0100, run, check state count and illegal flag
    task automatic do_op(input logic [7:0] b0, b1, b2, b3, input int st, input logic ill);
        int n;
        preload(STU_SEL_PROG_COUNTER, 16'h0100);
        i_mem.mem[16'h0100] = b0;
        i_mem.mem[16'h0101] = b1;
        i_mem.mem[16'h0102] = b2;
        i_mem.mem[16'h0103] = b3;
        @(posedge sys_clk_i) start_i <= 1'b1;
        @(posedge sys_clk_i) start_i <= 1'b0;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end while (done_o !== 1'b1 && n < 200);
        if (st >= 0) chk("clock states", 16'(st), 16'(n));
        chk("illegal flag", {15'h0000, ill}, {15'h0000, illegal_o});
    endtask : do_op

    // Register view by selector code
    function automatic logic [15:0] reg_of(input int i);
        case (i)
            0: return regs_o.pair_zero;
            1: return regs_o.pair_one;
            2: return regs_o.pair_two;
            3: return regs_o.accum_flags_pair;
            4: return regs_o.first_index_register;
            default: return regs_o.second_index_register;
        endcase
    endfunction : reg_of

    // Second index to absolute address, low byte first
    task automatic t_store_abs();
        preload(STU_SEL_SECOND_INDEX, 16'h4174);
        do_op(8'hfd, 8'h22, 8'h38, 8'h88, 20, 1'b0);
        chk("abs low", 16'h0074, {8'h00, i_mem.mem[16'h8838]});
        chk("abs high", 16'h0041, {8'h00, i_mem.mem[16'h8839]});
    endtask : t_store_abs

    // Stack pointer from pair_two, first and second index
    task automatic t_sp_load();
        logic [15:0] v;
        for (int i = 0; i < 3; i++) begin
            v = 16'h442e + 16'(i) * 16'h1111;
            preload(i == 0 ? STU_SEL_PAIR_TWO : stu_sel_e'(i + 3), v);
            if (i == 0) do_op(8'hf9, 8'h00, 8'h00, 8'h00, 6, 1'b0);
            else do_op(i == 1 ? 8'hdd : 8'hfd, 8'hf9, 8'h00, 8'h00, 10, 1'b0);
            chk("sp copy", v, regs_o.stack_pointer);
        end
    endtask : t_sp_load

    // Push each pair and each index register
    task automatic t_push();
        logic [15:0] v;
        for (int i = 0; i < 6; i++) begin
            v = 16'h2233 + 16'(i) * 16'h0101;
            preload(stu_sel_e'(i), v);
            preload(STU_SEL_STACK_POINTER, 16'h1007);
            if (i < 4) do_op({2'h3, 2'(i), 4'h5}, 8'h00, 8'h00, 8'h00, 11, 1'b0);
            else do_op(i == 4 ? 8'hdd : 8'hfd, 8'he5, 8'h00, 8'h00, 15, 1'b0);
            chk("push high", {8'h00, v[15:8]}, {8'h00, i_mem.mem[16'h1006]});
            chk("push low", {8'h00, v[7:0]}, {8'h00, i_mem.mem[16'h1005]});
            chk("push sp", 16'h1005, regs_o.stack_pointer);
        end
    endtask : t_push

    // Pop into each pair and each index register
    task automatic t_pop();
        for (int i = 0; i < 6; i++) begin
            i_mem.mem[16'h1000] = 8'h55;
            i_mem.mem[16'h1001] = 8'h33 + 8'(i);
            preload(STU_SEL_STACK_POINTER, 16'h1000);
            if (i < 4) do_op({2'h3, 2'(i), 4'h1}, 8'h00, 8'h00, 8'h00, 10, 1'b0);
            else do_op(i == 4 ? 8'hdd : 8'hfd, 8'he1, 8'h00, 8'h00, 14, 1'b0);
            chk("pop value", {8'h33 + 8'(i), 8'h55}, reg_of(i));
            chk("pop sp", 16'h1002, regs_o.stack_pointer);
        end
    endtask : t_pop

    // Opcode outside the group is flagged
    task automatic t_illegal();
        do_op(8'hdd, 8'h22, 8'h00, 8'h00, 8, 1'b1);
    endtask : t_illegal

    // Report and end the run
    task automatic print_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    // Hang guard, far beyond the expected run
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        fail_count++;
        print_verdict();
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        t_store_abs();
        t_sp_load();
        t_push();
        t_pop();
        t_illegal();
        print_verdict();
    end
endmodule : tb
